// [core/flash_command_sequencer.sv]
// Flash command sequencer: AXI4-Lite register file, command write sequence,
// two-deep command queue, status flags and the timebase divider.
// Assumes a single clock, inputs synchronous to it, and software that keeps
// its own side of the command write sequence.
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "flash_seq_consts.svh"

module flash_command_sequencer
  import flash_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_request,
  input wire logic special_mode,
  output logic buffer_empty_irq,
  output logic command_complete_irq
);

  ctl_state_type r_reg;
  ctl_state_type r_next;
  flash_engine_if eif ();

  logic buffer_empty_flag;
  logic command_complete_flag;
  logic idle_flag;
  logic [7:0] status_view;
  logic wr_fire;
  logic rd_fire;
  logic [3:0] wr_idx;
  logic [3:0] rd_idx;
  logic wr_mapped;
  logic rd_mapped;
  logic lane0;
  logic [7:0] wbyte;
  logic launch_req;
  logic [7:0] cmd_masked;
  logic cmd_legal;
  logic [31:0] rd_value;
  logic set_access_error;
  logic set_protection_violation;
  logic set_failure;
  logic set_erased_verified;
  logic clr_access_error;
  logic clr_protection_violation;
  logic clr_failure;
  logic clr_erased_verified;

  flash_array_engine engine (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .eif(eif.eng)
  );

  // ----------------------------------------
  // Derived flags and engine hand-off
  // ----------------------------------------
  // second stage loads as soon as the engine is free
  assign eif.start = r_reg.buf_valid & eif.ready;
  assign eif.cmd = r_reg.cmd_buf;
  assign eif.addr = r_reg.addr_hold;
  assign eif.data = r_reg.data_hold;
  assign eif.tick = (r_reg.div_count == r_reg.divider);
  assign eif.rd_index = r_reg.addr_hold[13:1];

  // empty when the buffer stage is free; complete when all is idle
  assign buffer_empty_flag = ~r_reg.buf_valid;
  assign command_complete_flag = ~r_reg.buf_valid & eif.ready;
  // idle flag only meaningful in special modes
  assign idle_flag = special_mode & eif.ready & ~r_reg.buf_valid;

  // one interrupt each for buffer empty and command complete, each gated by its enable
  assign buffer_empty_irq = buffer_empty_flag & r_reg.irq_enable[`IE_BUFFER_EMPTY];
  assign command_complete_irq = command_complete_flag & r_reg.irq_enable[`IE_COMMAND_COMPLETE];

  always_comb begin
    status_view = 8'h00;
    status_view[`ST_BUFFER_EMPTY] = buffer_empty_flag;
    status_view[`ST_COMMAND_COMPLETE] = command_complete_flag;
    status_view[`ST_PROTECTION_VIOLATION] = r_reg.protection_violation;
    status_view[`ST_ACCESS_ERROR] = r_reg.access_error;
    // after a verify, a zero here means not erased
    status_view[`ST_ERASED_VERIFIED] = r_reg.erased_verified;
    status_view[`ST_FAILURE] = r_reg.failure;
    status_view[`ST_IDLE] = idle_flag;
  end

  // ----------------------------------------
  // Bus handshakes
  // ----------------------------------------
  // Up to two writes and one read in flight; each channel is taken when its holder is free
  assign s_axi_awready = ~r_reg.aw_full;
  assign s_axi_wready = ~r_reg.w_full;
  assign s_axi_arready = ~r_reg.rvalid;
  assign s_axi_bvalid = r_reg.bvalid;
  assign s_axi_bresp = r_reg.bresp;
  assign s_axi_rvalid = r_reg.rvalid;
  assign s_axi_rdata = r_reg.rdata;
  assign s_axi_rresp = r_reg.rresp;

  assign wr_fire = r_reg.aw_full & r_reg.w_full & ~r_reg.bvalid;
  assign rd_fire = s_axi_arvalid & ~r_reg.rvalid;
  assign wr_idx = r_reg.aw_addr[5:2];
  assign rd_idx = s_axi_araddr[5:2];
  assign lane0 = r_reg.w_strb[0];
  assign wbyte = r_reg.w_data[7:0];
  assign cmd_masked = wbyte & `CMD_WRITABLE_MASK;
  assign cmd_legal = (cmd_masked == `CMD_ERASE_VERIFY) || (cmd_masked == `CMD_PROGRAM) ||
                     (cmd_masked == `CMD_SECTOR_ERASE) || (cmd_masked == `CMD_MASS_ERASE);
  assign launch_req = wr_fire & wr_mapped & lane0 & (wr_idx == `IDX_FLASH_STATUS) &
                      wbyte[`ST_BUFFER_EMPTY];

  // Map decode, shared by both directions
  function automatic logic is_mapped(input logic [7:0] a);
    logic [3:0] i;
    i = a[5:2];
    is_mapped = (a[7:6] == 2'b00) && (a[1:0] == 2'b00) &&
                (i == `IDX_TIMEBASE_DIVIDER || i == `IDX_IRQ_ENABLE ||
                 i == `IDX_PROTECTION_CONFIG || i == `IDX_FLASH_STATUS ||
                 i == `IDX_FLASH_COMMAND || i == `IDX_ADDRESS_HOLDING ||
                 i == `IDX_DATA_HOLDING || i == `IDX_ARRAY_READBACK ||
                 i == `IDX_FACTORY_TEST_RESERVED);
  endfunction

  assign wr_mapped = is_mapped(r_reg.aw_addr);
  assign rd_mapped = is_mapped(s_axi_araddr);

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (rd_idx)
      `IDX_TIMEBASE_DIVIDER: rd_value[7:0] = r_reg.divider;
      `IDX_IRQ_ENABLE: rd_value[7:0] = r_reg.irq_enable;
      `IDX_PROTECTION_CONFIG: rd_value[7:0] = r_reg.protection;
      `IDX_FLASH_STATUS: rd_value[7:0] = status_view;
      // only the writable command bits are ever stored
      `IDX_FLASH_COMMAND: rd_value[7:0] = r_reg.cmd_buf;
      `IDX_ADDRESS_HOLDING: rd_value[15:0] = r_reg.addr_hold;
      `IDX_DATA_HOLDING: rd_value[15:0] = r_reg.data_hold;
      `IDX_ARRAY_READBACK: rd_value[15:0] = eif.rd_word;
      // factory test register always reads zero
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Flag set and clear terms
  // ----------------------------------------
  always_comb begin
    set_access_error = 1'b0;
    set_protection_violation = 1'b0;
    clr_erased_verified = 1'b0;
    // stop while a command runs is an access error
    if (stop_request && !command_complete_flag) begin
      set_access_error = 1'b1;
    end
    if (wr_fire && wr_mapped && lane0) begin
      unique case (wr_idx)
        `IDX_DATA_HOLDING: begin
          // array write only opens a sequence into an empty buffer
          if (r_reg.seq != seq_idle || r_reg.buf_valid) begin
            set_access_error = 1'b1;
          end
        end
        `IDX_FLASH_COMMAND: begin
          // command out of order, or an unsupported code
          if (r_reg.seq != seq_data || !cmd_legal) begin
            set_access_error = 1'b1;
          end
        end
        `IDX_FLASH_STATUS: begin
          if (launch_req && r_reg.seq != seq_cmd && r_reg.seq != seq_idle) begin
            set_access_error = 1'b1;
          end else if (launch_req && r_reg.seq == seq_cmd && !r_reg.access_error &&
                       !r_reg.protection_violation && !r_reg.failure) begin
            // mass erase needs every protection disable set
            if (r_reg.cmd_buf == `CMD_MASS_ERASE &&
                !(r_reg.protection[`PROT_OPEN] && r_reg.protection[`PROT_HIGH_DISABLE] &&
                  r_reg.protection[`PROT_LOW_DISABLE])) begin
              set_protection_violation = 1'b1;
            // program or erase into a protected array
            end else if (r_reg.cmd_buf != `CMD_ERASE_VERIFY && !r_reg.protection[`PROT_OPEN]) begin
              set_protection_violation = 1'b1;
            end else begin
              // hardware clears the erased flag on a valid launch
              clr_erased_verified = 1'b1;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // one-to-clear on status, except access error in a write that also sets the launch bit; written zeros do nothing
  assign clr_access_error = launch_req ? 1'b0 : (wr_fire & wr_mapped & lane0 &
                            (wr_idx == `IDX_FLASH_STATUS) & wbyte[`ST_ACCESS_ERROR]);
  assign clr_protection_violation = wr_fire & wr_mapped & lane0 & (wr_idx == `IDX_FLASH_STATUS) &
                                    wbyte[`ST_PROTECTION_VIOLATION];
  assign clr_failure = wr_fire & wr_mapped & lane0 & (wr_idx == `IDX_FLASH_STATUS) &
                       wbyte[`ST_FAILURE];
  // blank verify outcome sets the erased flag
  assign set_erased_verified = eif.verify_done & eif.verify_blank;
  // failed verify only flags failure in special modes
  assign set_failure = eif.verify_done & ~eif.verify_blank & special_mode;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    r_next = r_reg;
    // Divider runs freely; the engine steps on its wrap
    r_next.div_count = eif.tick ? 8'h00 : r_reg.div_count + 8'h01;
    // Channel capture
    if (s_axi_awvalid && !r_reg.aw_full) begin
      r_next.aw_full = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r_reg.w_full) begin
      r_next.w_full = 1'b1;
      r_next.w_data = s_axi_wdata;
      r_next.w_strb = s_axi_wstrb;
    end
    if (r_reg.bvalid && s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.rvalid && s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    if (rd_fire) begin
      r_next.rvalid = 1'b1;
      r_next.rdata = rd_mapped ? rd_value : 32'h0000_0000;
      r_next.rresp = rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end
    // engine took the queued command, buffer frees up
    if (eif.start) begin
      r_next.buf_valid = 1'b0;
    end
    // Register writes and the command write sequence
    if (wr_fire) begin
      r_next.aw_full = 1'b0;
      r_next.w_full = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      if (wr_mapped && lane0) begin
        unique case (wr_idx)
          `IDX_TIMEBASE_DIVIDER: r_next.divider = wbyte;
          `IDX_IRQ_ENABLE: r_next.irq_enable = wbyte;
          `IDX_PROTECTION_CONFIG: r_next.protection = wbyte;
          `IDX_ADDRESS_HOLDING: begin
            if (r_reg.seq == seq_idle && !r_reg.buf_valid) begin
              r_next.addr_hold = {(r_reg.w_strb[1] ? r_reg.w_data[15:8] : r_reg.addr_hold[15:8]), wbyte};
            end
          end
          // array write opens the sequence; data is don't-care for erases
          `IDX_DATA_HOLDING: begin
            if (r_reg.seq == seq_idle && !r_reg.buf_valid) begin
              r_next.data_hold = {(r_reg.w_strb[1] ? r_reg.w_data[15:8] : r_reg.data_hold[15:8]), wbyte};
              r_next.seq = seq_data;
            end else begin
              r_next.seq = seq_idle;
            end
          end
          `IDX_FLASH_COMMAND: begin
            if (r_reg.seq == seq_data && cmd_legal) begin
              r_next.cmd_buf = cmd_masked;
              r_next.seq = seq_cmd;
            end else begin
              r_next.seq = seq_idle;
            end
          end
          `IDX_FLASH_STATUS: begin
            if (launch_req && r_reg.seq != seq_idle) begin
              r_next.seq = seq_idle;
              // queued launch keeps the complete flag low until it drains
              if (!set_protection_violation && r_reg.seq == seq_cmd && !r_reg.access_error &&
                  !r_reg.protection_violation && !r_reg.failure) begin
                r_next.buf_valid = 1'b1;
              end
            end
          end
          // factory test register and readback ignore writes
          default: begin
          end
        endcase
      end
    end
    // Set wins over a clear in the same cycle
    r_next.access_error = (r_reg.access_error & ~clr_access_error) | set_access_error;
    r_next.protection_violation = (r_reg.protection_violation & ~clr_protection_violation) |
                                  set_protection_violation;
    r_next.failure = (r_reg.failure & ~clr_failure) | set_failure;
    r_next.erased_verified = (r_reg.erased_verified & ~clr_erased_verified) | set_erased_verified;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '{seq: seq_idle, divider: `DIVIDER_RESET, protection: `PROTECTION_RESET, default: '0};
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

endmodule

// [shared/flash_seq_consts.svh]
// Offsets, field positions, reset values and sizes of the flash command sequencer.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH

// ----------------------------------------
// Register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_TIMEBASE_DIVIDER 4'h2
`define IDX_IRQ_ENABLE 4'h3
`define IDX_PROTECTION_CONFIG 4'h4
`define IDX_FLASH_STATUS 4'h5
`define IDX_FLASH_COMMAND 4'h6
`define IDX_ADDRESS_HOLDING 4'h8
`define IDX_DATA_HOLDING 4'ha
`define IDX_ARRAY_READBACK 4'hc
`define IDX_FACTORY_TEST_RESERVED 4'hf

// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define ST_BUFFER_EMPTY 7
`define ST_COMMAND_COMPLETE 6
`define ST_PROTECTION_VIOLATION 5
`define ST_ACCESS_ERROR 4
`define ST_ERASED_VERIFIED 2
`define ST_FAILURE 1
`define ST_IDLE 0

// ----------------------------------------
// Protection and interrupt-enable bit positions
// ----------------------------------------
`define PROT_OPEN 7
`define PROT_HIGH_DISABLE 5
`define PROT_LOW_DISABLE 2
`define IE_BUFFER_EMPTY 7
`define IE_COMMAND_COMPLETE 6

// ----------------------------------------
// Command codes and writable command bits
// ----------------------------------------
`define CMD_ERASE_VERIFY 8'h05
`define CMD_PROGRAM 8'h20
`define CMD_SECTOR_ERASE 8'h40
`define CMD_MASS_ERASE 8'h41
`define CMD_WRITABLE_MASK 8'h65

// ----------------------------------------
// Array geometry and reset values
// ----------------------------------------
`define ARRAY_WORDS 8192
`define SECTOR_WORD_BITS 9
`define ERASED_WORD 16'hffff
`define DIVIDER_RESET 8'h00
`define PROTECTION_RESET 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [shared/flash_seq_pkg.sv]
// Types shared by the flash command sequencer and its array engine.
// Assumes flash_seq_consts.svh is on the include path.
`include "flash_seq_consts.svh"

package flash_seq_pkg;

  typedef enum logic [1:0] {seq_idle, seq_data, seq_cmd} seq_state_type;
  typedef enum logic {eng_idle, eng_run} eng_state_type;

  // All state of the register and sequencing side
  typedef struct packed {
    seq_state_type seq;
    logic [7:0] divider;
    logic [7:0] div_count;
    logic [7:0] irq_enable;
    logic [7:0] protection;
    logic [7:0] cmd_buf;
    logic [15:0] addr_hold;
    logic [15:0] data_hold;
    logic buf_valid;
    logic access_error;
    logic protection_violation;
    logic erased_verified;
    logic failure;
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_state_type;

  // All state of the array engine
  typedef struct packed {
    eng_state_type st;
    logic [7:0] cmd;
    logic [12:0] ptr;
    logic [12:0] last;
    logic [15:0] data;
    logic all_blank;
    logic verify_done;
    logic verify_blank;
  } eng_regs_type;

endpackage

// [shared/flash_engine_if.sv]
// Carrier between the command sequencer and the array engine.
// Assumes both sides run on the same clock.
`timescale 1ns/100ps

interface flash_engine_if;
  logic start;
  logic [7:0] cmd;
  logic [15:0] addr;
  logic [15:0] data;
  logic tick;
  logic ready;
  logic verify_done;
  logic verify_blank;
  logic [12:0] rd_index;
  logic [15:0] rd_word;

  modport seq (output start, cmd, addr, data, tick, rd_index,
               input ready, verify_done, verify_blank, rd_word);
  modport eng (input start, cmd, addr, data, tick, rd_index,
               output ready, verify_done, verify_blank, rd_word);
endinterface

// [core/flash_array_engine.sv]
// Array engine: executes one launched command on the word array.
// Assumes start arrives only while ready is high and tick is a one-cycle strobe.
`timescale 1ns/100ps
`include "flash_seq_consts.svh"

module flash_array_engine
  import flash_seq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  flash_engine_if.eng eif
);

  eng_regs_type r_reg;
  eng_regs_type r_next;
  logic [15:0] mem_reg [`ARRAY_WORDS];
  logic wr_en;
  logic [12:0] wr_index;
  logic [15:0] wr_word;

  assign eif.ready = (r_reg.st == eng_idle);
  assign eif.verify_done = r_reg.verify_done;
  assign eif.verify_blank = r_reg.verify_blank;
  assign eif.rd_word = mem_reg[eif.rd_index];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // One word per timebase tick, so run time scales with the divider
  always_comb begin
    r_next = r_reg;
    r_next.verify_done = 1'b0;
    wr_en = 1'b0;
    wr_index = r_reg.ptr;
    wr_word = `ERASED_WORD;
    unique case (r_reg.st)
      eng_idle: begin
        if (eif.start) begin
          r_next.st = eng_run;
          r_next.cmd = eif.cmd;
          r_next.data = eif.data;
          r_next.all_blank = 1'b1;
          if (eif.cmd == `CMD_PROGRAM) begin
            r_next.ptr = eif.addr[13:1];
            r_next.last = eif.addr[13:1];
          end else if (eif.cmd == `CMD_SECTOR_ERASE) begin
            r_next.ptr = {eif.addr[13:10], 9'h000};
            r_next.last = {eif.addr[13:10], 9'h1ff};
          end else begin
            r_next.ptr = 13'h0000;
            r_next.last = 13'h1fff;
          end
        end
      end
      eng_run: begin
        if (eif.tick) begin
          unique case (r_reg.cmd)
            `CMD_ERASE_VERIFY: begin
              if (mem_reg[r_reg.ptr] != `ERASED_WORD) begin
                r_next.all_blank = 1'b0;
              end
            end
            `CMD_PROGRAM: begin
              wr_en = 1'b1;
              wr_word = r_reg.data;
            end
            default: begin
              wr_en = 1'b1;
            end
          endcase
          if (r_reg.ptr == r_reg.last) begin
            r_next.st = eng_idle;
            if (r_reg.cmd == `CMD_ERASE_VERIFY) begin
              r_next.verify_done = 1'b1;
              r_next.verify_blank = r_next.all_blank;
            end
          end else begin
            r_next.ptr = r_reg.ptr + 13'h0001;
          end
        end
      end
    endcase
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '{st: eng_idle, default: '0};
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // Array cells; reset to erased stands in for a blank part
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < `ARRAY_WORDS; i++) begin
        mem_reg[i] <= `ERASED_WORD;
      end
    end else if (ce && wr_en) begin
      mem_reg[wr_index] <= wr_word;
    end
  end

endmodule

// [tb/flash_seq_chk.sv]
// Checker: bus handshake and status relations at the sequencer ports.
// Assumes ce held high and one write and one read at a time.
`timescale 1ns/100ps
module flash_seq_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic buffer_empty_irq
);
  logic [7:0] ra_reg;
  logic [7:0] wa_reg;
  // Remember the address each answer belongs to
  always_ff @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
    if (s_axi_awvalid && s_axi_awready) wa_reg <= s_axi_awaddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  AST_ARRDY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  AST_RLAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_BLAT: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  AST_RDHI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  AST_CMDRD: assert property (s_axi_rvalid && ra_reg == 8'h18 |-> (s_axi_rdata & ~32'h65) == 32'h0)
    else $error("fixed command bits not zero");
  AST_FTZ: assert property (s_axi_rvalid && ra_reg == 8'h3c |-> s_axi_rdata == 32'h0)
    else $error("factory test register not zero");
  AST_IRQ: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h14 && buffer_empty_irq
    |=> s_axi_rdata[7]) else $error("irq without empty flag");
  AST_SLV: assert property (s_axi_bvalid && wa_reg == 8'h04 |-> s_axi_bresp == 2'b10)
    else $error("unmapped write not refused");
  // Main scenarios reached
  cover property (s_axi_rvalid && ra_reg == 8'h14);
  cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
  cover property (buffer_empty_irq);
endmodule

// [tb/axi_lite_master.sv]
// Partner: AXI4-Lite master standing in for the CPU software.
// Assumes slave readies and valids change only at rising edges.
`timescale 1ns/100ps
module axi_lite_master (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  logic a, w, b; // Handshakes seen before the edge
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Write: both channels together, each released when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r, output bit ok);
    ok = 0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {ad, d, 3'b111};
    for (int n = 0; n < 200 && !ok; n++) begin
      @(negedge aclk); // Sample away from the edge, act on it
      {a, w, b} = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_bvalid};
      r = s_axi_bresp;
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) s_axi_bready <= 1'b0;
      ok = b;
    end
  endtask
  // Read: rready held high until the answer is taken
  task automatic rd(input logic [7:0] ad, output logic [31:0] d, output bit ok);
    ok = 0;
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {ad, 2'b11};
    for (int n = 0; n < 200 && !ok; n++) begin
      @(negedge aclk);
      {a, b} = {s_axi_arready & s_axi_arvalid, s_axi_rvalid};
      d = s_axi_rdata;
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
      if (b) s_axi_rready <= 1'b0;
      ok = b;
    end
  endtask
endmodule

// [tb/flash_command_sequencer_tb.sv]
// Testbench: register table, command sequences, flags and queue.
// Assumes design, partner and checker compiled before it.
`timescale 1ns/100ps
module flash_command_sequencer_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic stop_request = 1'b0;
  logic special_mode = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, buffer_empty_irq, command_complete_irq;
  int fail_count = 0;
  int check_count = 0;
  bit ok;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_type;
  row_type rows [5] = '{'{8'h08, 32'h100, 32'h0}, '{8'h0c, 32'hc0, 32'hc0},
    '{8'h10, 32'h24, 32'h24}, '{8'h3c, 32'hff, 32'h0}, '{8'h04, 32'h5, 32'h0}};
  always #12.5 aclk = ~aclk;
  flash_command_sequencer flash_command_sequencer_inst (.*);
  axi_lite_master axi_lite_master_inst (.*);
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic hang;
    fail_count++;
    $display("[ERR] %0t no answer", $time);
    print_verdict();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      $display("[ERR] %0t got %h want %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    axi_lite_master_inst.wr(a, d, r, ok);
    if (!ok) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    axi_lite_master_inst.rd(a, v, ok);
    if (!ok) hang();
  endtask
  task automatic st(input logic [31:0] e);
    rd(8'h14);
    chk(v, e);
  endtask
  // Full command write sequence ending in a launch
  task automatic seq(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d);
    w(8'h20, {16'h0, a});
    w(8'h28, {16'h0, d});
    w(8'h18, {24'h0, c});
    w(8'h14, 32'h80);
  endtask
  // Poll the complete flag, bounded
  task automatic wait_done;
    for (int n = 0; n < 5000; n++) begin
      rd(8'h14);
      if (v[6] === 1'b1) return;
    end
    hang();
  endtask
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    st(32'hc0); // reset status
    special_mode <= 1'b1;
    st(32'hc1); // idle flag
    foreach (rows[i]) begin
      w(rows[i].a, rows[i].d);
      chk(32'(r), (rows[i].a == 8'h04) ? 32'h2 : 32'h0);
      rd(rows[i].a);
      chk(v, rows[i].e); // table readback
      chk(32'(s_axi_rresp), 32'(r));
    end
    $display("test registers done");
    w(8'h28, 32'h0);
    w(8'h18, 32'h06);
    st(32'hd1); // illegal code
    w(8'h14, 32'h0);
    st(32'hd1); // zero write kept
    w(8'h14, 32'h10);
    st(32'hc1); // one clears
    w(8'h28, 32'h0);
    w(8'h18, 32'h41);
    rd(8'h18);
    chk(v, 32'h41); // command readback
    w(8'h14, 32'h80);
    st(32'he1); // protected mass erase
    w(8'h14, 32'h20);
    st(32'hc1); // violation cleared
    $display("test errors done");
    seq(8'h05, 16'h0, 16'h0);
    wait_done();
    st(32'hc5); // blank array
    w(8'h10, 32'h80);
    seq(8'h20, 16'h4, 16'h1234);
    wait_done();
    st(32'hc1); // cleared by launch
    chk(32'({buffer_empty_irq, command_complete_irq}), 32'h3);
    rd(8'h30);
    chk(v, 32'h1234); // word programmed
    seq(8'h05, 16'h0, 16'h0);
    wait_done();
    st(32'hc3); // not erased
    w(8'h14, 32'h02);
    seq(8'h40, 16'h4, 16'h0);
    seq(8'h20, 16'h800, 16'h5678);
    st(32'h00); // queued behind erase
    chk(32'({buffer_empty_irq, command_complete_irq}), 32'h0);
    wait_done();
    w(8'h20, 32'h4);
    rd(8'h30);
    chk(v, 32'hffff); // sector erased
    w(8'h20, 32'h800);
    rd(8'h30);
    chk(v, 32'h5678); // queued program done
    seq(8'h05, 16'h0, 16'h0);
    stop_request <= 1'b1;
    @(posedge aclk);
    stop_request <= 1'b0;
    wait_done();
    st(32'hd3); // stop while busy
    $display("test commands done");
    print_verdict();
  end
endmodule
bind flash_command_sequencer flash_seq_chk flash_seq_chk_inst (.*);
